// File: design/rtc_alarm_pkg.sv
package rtc_alarm_pkg;
   // register indices; the byte address is four times the index
   localparam logic [5:0] IDX_CLOCK_MM = 6'h01;
   localparam logic [5:0] IDX_CLOCK_HOUR = 6'h02;
   localparam logic [5:0] IDX_CLOCK_WEEKDAY = 6'h03;
   localparam logic [5:0] IDX_CLOCK_DATE = 6'h04;
   localparam logic [5:0] IDX_ALARM_MM = 6'h08;
   localparam logic [5:0] IDX_ALARM_HOUR = 6'h09;
   localparam logic [5:0] IDX_ALARM_WD = 6'h0a;
   localparam logic [5:0] IDX_FUNC_SEL = 6'h0d;
   localparam logic [5:0] IDX_EVENT_FLAGS = 6'h0e;
   localparam logic [5:0] IDX_INT_CTRL = 6'h0f;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h11;
   // word index position inside a byte address
   localparam int unsigned IDX_LSB = 2;
   localparam int unsigned IDX_MSB = 7;
   // field positions
   localparam int unsigned BIT_CMP_DISABLE = 7;
   localparam int unsigned BIT_TARGET_SEL = 6;
   localparam int unsigned BIT_ALARM_FLAG = 3;
   localparam int unsigned BIT_ALARM_EN = 3;
   localparam int unsigned BIT_CLOCK_HALT = 1;
   localparam int unsigned BIT_IRQ_ALARM = 0;
   // bcd and weekday field widths
   localparam int unsigned MIN_W = 7;
   localparam int unsigned HOUR_W = 6;
   localparam int unsigned DATE_W = 6;
   localparam int unsigned WEEK_W = 7;
   // reset values
   localparam logic [7:0] ALARM_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: design/alarm_match_interrupt.sv
`timescale 1ns/100ps
// Functional notes
// - alarm event when enabled fields equal time
// - event only when counters advance into match
// - event sets flag, held until zero written
// - writing one to flag does nothing
// - enabled event pulls interrupt low, no timeout
// - enable cleared releases interrupt at once
// - flag cleared releases interrupt immediately
// - while flag set, pin follows enable
// - disabled event sets flag, pin stays released
// - pin shared with other interrupt sources
// - clock halt blocks all alarm events
// - target select picks weekday or date compare
// - weekday mode bits six..zero select days
// - bit seven excludes that register from compare
// - all fields disabled gives event every minute
// - bcd field weights match time counters
module alarm_match_interrupt #(
   parameter int unsigned ADDR_W = 8 // axi address width, at least 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] cur_minute, // bcd minute from the time counters
   input wire logic [7:0] cur_hour, // bcd hour
   input wire logic [7:0] cur_weekday, // one-hot weekday
   input wire logic [7:0] cur_date, // bcd date
   input wire logic other_irq_req, // low request of the other sources
   output logic irq_n_out, // open-drain level, always low
   output logic irq_n_oe, // high while the pin is pulled low
   output logic irq // level interrupt to the local system
);

   // decoded word index of a byte address
   function automatic logic [5:0] word_idx(input logic [ADDR_W-1:0] a);
      word_idx = a[rtc_alarm_pkg::IDX_MSB:rtc_alarm_pkg::IDX_LSB];
   endfunction

   // true for any index that holds a register
   function automatic logic is_mapped(input logic [5:0] idx);
      case (idx)
         rtc_alarm_pkg::IDX_CLOCK_MM, rtc_alarm_pkg::IDX_CLOCK_HOUR,
         rtc_alarm_pkg::IDX_CLOCK_WEEKDAY, rtc_alarm_pkg::IDX_CLOCK_DATE,
         rtc_alarm_pkg::IDX_ALARM_MM, rtc_alarm_pkg::IDX_ALARM_HOUR,
         rtc_alarm_pkg::IDX_ALARM_WD, rtc_alarm_pkg::IDX_FUNC_SEL,
         rtc_alarm_pkg::IDX_EVENT_FLAGS, rtc_alarm_pkg::IDX_INT_CTRL,
         rtc_alarm_pkg::IDX_IRQ_STATUS, rtc_alarm_pkg::IDX_IRQ_MASK: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // write channel holding state
   logic aw_hold_q; // address taken, waiting for data
   logic [5:0] aw_idx_q; // index of the pending write
   logic w_hold_q; // data taken, waiting for address
   logic [7:0] w_byte_q; // low byte of the pending write
   logic w_lane_q; // low byte lane enabled
   logic bvalid_q; // write response pending
   logic [1:0] bresp_q; // write response code
   logic rvalid_q; // read response pending
   logic [31:0] rdata_q; // read data
   logic [1:0] rresp_q; // read response code
   logic wr_fire; // both halves present, commit the write
   logic [7:0] rd_mux; // read value of the addressed register
   logic [5:0] rd_idx; // index of the incoming read

   // stored registers
   logic [7:0] alarm_mm_q;
   logic [7:0] alarm_hour_q;
   logic [7:0] alarm_wd_q;
   logic [7:0] func_sel_q;
   logic [7:0] int_ctrl_q;
   logic alarm_event_flag_q; // sticky alarm flag
   logic irq_status_q; // sticky status of the local interrupt
   logic irq_mask_q; // local interrupt mask
   // time change detection
   logic [7:0] minute_seen_q; // minute value of the previous cycle
   logic time_valid_q; // a previous minute has been captured
   // alarm datapath
   logic minute_changed; // counters advanced this cycle
   logic min_ok, hour_ok, day_ok, alarm_match, alarm_event;
   logic alarm_interrupt_enable, alarm_target_select, clock_halt;
   logic wr_flags, wr_flag_clear, wr_status_clear;

   assign wr_fire = aw_hold_q & w_hold_q;
   assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
   assign s_axi_wready = ~w_hold_q & ~bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign rd_idx = word_idx(s_axi_araddr);

   // write address and data are taken in either order
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         aw_hold_q <= 1'b0;
         aw_idx_q <= 6'h00;
         w_hold_q <= 1'b0;
         w_byte_q <= rtc_alarm_pkg::ZERO_BYTE;
         w_lane_q <= 1'b0;
      end else if (wr_fire) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_idx_q <= word_idx(s_axi_awaddr);
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_byte_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
         end
      end
   end

   // write response, error for an unmapped index
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q <= rtc_alarm_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= is_mapped(aw_idx_q) ? rtc_alarm_pkg::RESP_OKAY : rtc_alarm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // read value of each register, reserved bits zero
   always_comb begin
      rd_mux = rtc_alarm_pkg::ZERO_BYTE;
      case (rd_idx)
         rtc_alarm_pkg::IDX_CLOCK_MM: rd_mux = cur_minute;
         rtc_alarm_pkg::IDX_CLOCK_HOUR: rd_mux = cur_hour;
         rtc_alarm_pkg::IDX_CLOCK_WEEKDAY: rd_mux = cur_weekday;
         rtc_alarm_pkg::IDX_CLOCK_DATE: rd_mux = cur_date;
         rtc_alarm_pkg::IDX_ALARM_MM: rd_mux = alarm_mm_q;
         rtc_alarm_pkg::IDX_ALARM_HOUR: rd_mux = alarm_hour_q;
         rtc_alarm_pkg::IDX_ALARM_WD: rd_mux = alarm_wd_q;
         rtc_alarm_pkg::IDX_FUNC_SEL: rd_mux = func_sel_q;
         rtc_alarm_pkg::IDX_EVENT_FLAGS: rd_mux[rtc_alarm_pkg::BIT_ALARM_FLAG] = alarm_event_flag_q;
         rtc_alarm_pkg::IDX_INT_CTRL: rd_mux = int_ctrl_q;
         rtc_alarm_pkg::IDX_IRQ_STATUS: rd_mux[rtc_alarm_pkg::BIT_IRQ_ALARM] = irq_status_q;
         rtc_alarm_pkg::IDX_IRQ_MASK: rd_mux[rtc_alarm_pkg::BIT_IRQ_ALARM] = irq_mask_q;
         default: rd_mux = rtc_alarm_pkg::ZERO_BYTE;
      endcase
   end

   // read channel, one cycle after the address is taken
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= rtc_alarm_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q <= {24'h00_0000, rd_mux};
         rresp_q <= is_mapped(rd_idx) ? rtc_alarm_pkg::RESP_OKAY : rtc_alarm_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // alarm and control registers, written on byte lane zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         alarm_mm_q <= rtc_alarm_pkg::ALARM_RST;
         alarm_hour_q <= rtc_alarm_pkg::ALARM_RST;
         alarm_wd_q <= rtc_alarm_pkg::ALARM_RST;
         func_sel_q <= rtc_alarm_pkg::CTRL_RST;
         int_ctrl_q <= rtc_alarm_pkg::CTRL_RST;
         irq_mask_q <= 1'b0;
      end else if (wr_fire && w_lane_q) begin
         case (aw_idx_q)
            rtc_alarm_pkg::IDX_ALARM_MM: alarm_mm_q <= w_byte_q;
            rtc_alarm_pkg::IDX_ALARM_HOUR: alarm_hour_q <= w_byte_q;
            rtc_alarm_pkg::IDX_ALARM_WD: alarm_wd_q <= w_byte_q;
            rtc_alarm_pkg::IDX_FUNC_SEL: func_sel_q <= w_byte_q;
            rtc_alarm_pkg::IDX_INT_CTRL: int_ctrl_q <= w_byte_q;
            rtc_alarm_pkg::IDX_IRQ_MASK: irq_mask_q <= w_byte_q[rtc_alarm_pkg::BIT_IRQ_ALARM];
            default: ;
         endcase
      end
   end

   assign alarm_interrupt_enable = int_ctrl_q[rtc_alarm_pkg::BIT_ALARM_EN];
   assign clock_halt = int_ctrl_q[rtc_alarm_pkg::BIT_CLOCK_HALT];
   assign alarm_target_select = func_sel_q[rtc_alarm_pkg::BIT_TARGET_SEL];

   // field compares, each skipped when its disable bit is set
   assign min_ok = alarm_mm_q[rtc_alarm_pkg::BIT_CMP_DISABLE] |
      (alarm_mm_q[rtc_alarm_pkg::MIN_W-1:0] == cur_minute[rtc_alarm_pkg::MIN_W-1:0]);
   assign hour_ok = alarm_hour_q[rtc_alarm_pkg::BIT_CMP_DISABLE] |
      (alarm_hour_q[rtc_alarm_pkg::HOUR_W-1:0] == cur_hour[rtc_alarm_pkg::HOUR_W-1:0]);
   // date compare or any selected weekday
   assign day_ok = alarm_wd_q[rtc_alarm_pkg::BIT_CMP_DISABLE] |
      (alarm_target_select ?
       (alarm_wd_q[rtc_alarm_pkg::DATE_W-1:0] == cur_date[rtc_alarm_pkg::DATE_W-1:0]) :
       (|(alarm_wd_q[rtc_alarm_pkg::WEEK_W-1:0] &
          cur_weekday[rtc_alarm_pkg::WEEK_W-1:0])));
   assign alarm_match = min_ok & hour_ok & day_ok;

   // previous minute, so a match counts only on a counter advance
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         minute_seen_q <= rtc_alarm_pkg::ZERO_BYTE;
         time_valid_q <= 1'b0;
      end else begin
         minute_seen_q <= cur_minute;
         time_valid_q <= 1'b1;
      end
   end

   // any hour or date step carries a minute step, so it suffices
   assign minute_changed = time_valid_q & (cur_minute != minute_seen_q);
   assign alarm_event = alarm_match & minute_changed & ~clock_halt;

   // flag writes: only a zero clears, a one is ignored
   assign wr_flags = wr_fire & w_lane_q & (aw_idx_q == rtc_alarm_pkg::IDX_EVENT_FLAGS);
   assign wr_flag_clear = wr_flags & ~w_byte_q[rtc_alarm_pkg::BIT_ALARM_FLAG];
   assign wr_status_clear = wr_fire & w_lane_q & (aw_idx_q == rtc_alarm_pkg::IDX_IRQ_STATUS) &
      w_byte_q[rtc_alarm_pkg::BIT_IRQ_ALARM];

   // sticky alarm flag, a new event wins over a clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         alarm_event_flag_q <= 1'b0;
      end else if (alarm_event) begin
         alarm_event_flag_q <= 1'b1;
      end else if (wr_flag_clear) begin
         alarm_event_flag_q <= 1'b0;
      end
   end

   // local interrupt status, write one to clear, set wins
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_status_q <= 1'b0;
      end else if (alarm_event) begin
         irq_status_q <= 1'b1;
      end else if (wr_status_clear) begin
         irq_status_q <= 1'b0;
      end
   end

   // open-drain pin: alarm follows flag and enable, plus others
   assign irq_n_out = 1'b0;
   assign irq_n_oe = (alarm_event_flag_q & alarm_interrupt_enable) |
      other_irq_req;
   assign irq = irq_status_q & irq_mask_q;

   // alarm event always lands in the flag
   AST_EVENT_SETS_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
      alarm_event |=> alarm_event_flag_q)
      else $error("alarm event did not set the flag");

   // flag holds until a zero write
   AST_FLAG_HOLDS: assert property (@(posedge sys_clk) disable iff (rst)
      alarm_event_flag_q && !wr_flag_clear |=> alarm_event_flag_q)
      else $error("alarm flag dropped without a clearing write");

   // a one written to the flag leaves it as it was, set or clear
   AST_WRITE_ONE_IGNORED: assert property (@(posedge sys_clk) disable iff (rst)
      wr_flags && w_byte_q[rtc_alarm_pkg::BIT_ALARM_FLAG] && !alarm_event
      |=> alarm_event_flag_q == $past(alarm_event_flag_q))
      else $error("writing one changed the alarm flag");

   // enabled and flagged, the pin is still low eight cycles after the event
   AST_PIN_HELD_LOW: assert property (@(posedge sys_clk) disable iff (rst)
      alarm_event && alarm_interrupt_enable ##1 (alarm_interrupt_enable && !wr_flag_clear)[*8]
      |-> irq_n_oe)
      else $error("enabled alarm released the pin on its own");

   // enable cleared releases the pin in the same cycle
   AST_RELEASE_ON_ENABLE: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(alarm_interrupt_enable) && !other_irq_req |-> !irq_n_oe)
      else $error("pin still low after enable cleared");

   // flag cleared releases the pin in the same cycle
   AST_RELEASE_ON_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(alarm_event_flag_q) && !other_irq_req |-> !irq_n_oe)
      else $error("pin still low after flag cleared");

   // with the flag set the pin tracks the enable
   AST_PIN_TRACKS_ENABLE: assert property (@(posedge sys_clk) disable iff (rst)
      alarm_event_flag_q && !other_irq_req |-> (irq_n_oe == alarm_interrupt_enable))
      else $error("pin does not follow the enable while flagged");

   // disabled event sets the flag but leaves the pin alone
   AST_DISABLED_EVENT: assert property (@(posedge sys_clk) disable iff (rst)
      alarm_event && !alarm_interrupt_enable ##1 !alarm_interrupt_enable && !other_irq_req
      |-> alarm_event_flag_q && !irq_n_oe)
      else $error("disabled alarm drove the pin");

   // another source may hold the pin low
   AST_OTHER_SOURCE: assert property (@(posedge sys_clk) disable iff (rst)
      other_irq_req |-> irq_n_oe && !irq_n_out)
      else $error("other request not seen on the pin");

   // halted clock gives no events
   AST_HALT_BLOCKS: assert property (@(posedge sys_clk) disable iff (rst)
      clock_halt |-> !alarm_event)
      else $error("alarm event while the clock is halted");

   // no advance of the minute, no event
   AST_NO_EVENT_WITHOUT_ADVANCE: assert property (@(posedge sys_clk) disable iff (rst)
      $stable(cur_minute) |-> !alarm_event)
      else $error("alarm event without a counter advance");

   // all compares disabled fires on every minute step
   AST_EVERY_MINUTE: assert property (@(posedge sys_clk) disable iff (rst)
      alarm_mm_q[rtc_alarm_pkg::BIT_CMP_DISABLE] && alarm_hour_q[rtc_alarm_pkg::BIT_CMP_DISABLE]
      && alarm_wd_q[rtc_alarm_pkg::BIT_CMP_DISABLE] && !clock_halt && time_valid_q
      && !$stable(cur_minute) |-> alarm_event)
      else $error("fully masked alarm missed a minute");

   // weekday mode matches any selected day
   AST_WEEKDAY_MATCH: assert property (@(posedge sys_clk) disable iff (rst)
      !alarm_target_select && !alarm_wd_q[rtc_alarm_pkg::BIT_CMP_DISABLE]
      |-> (day_ok == |(alarm_wd_q[rtc_alarm_pkg::WEEK_W-1:0] &
                       cur_weekday[rtc_alarm_pkg::WEEK_W-1:0])))
      else $error("weekday compare disagrees with the selected days");

   // scenario coverage
   COV_ENABLED_ALARM: cover property (@(posedge sys_clk) disable iff (rst)
      alarm_event && alarm_interrupt_enable ##1 irq_n_oe);
   COV_DATE_ALARM: cover property (@(posedge sys_clk) disable iff (rst)
      alarm_event && alarm_target_select);
   COV_CLEAR_RELEASE: cover property (@(posedge sys_clk) disable iff (rst)
      alarm_event_flag_q && alarm_interrupt_enable ##1 !alarm_event_flag_q);
   COV_SET_OVER_CLEAR: cover property (@(posedge sys_clk) disable iff (rst)
      alarm_event && wr_flag_clear);

endmodule

// File: verification/time_counter_model.sv
`timescale 1ns/100ps
// stand-in for the time counters and the pull-up on the shared interrupt pin
module time_counter_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic load, // take a new time at the next edge
   input wire logic [31:0] load_val, // minute, hour, weekday, date
   input wire logic irq_n_out,
   input wire logic irq_n_oe,
   output logic [7:0] cur_minute,
   output logic [7:0] cur_hour,
   output logic [7:0] cur_weekday,
   output logic [7:0] cur_date,
   output logic irq_pin // resolved pin level
);
   logic [31:0] time_q; // held time, changes only on load
   // counters jump to the loaded time in one step
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         time_q <= 32'h00000000;
      end else if (load) begin
         time_q <= load_val;
      end
   end
   assign {cur_minute, cur_hour, cur_weekday, cur_date} = time_q;
   // pull-up keeps the pin high unless some driver pulls it low
   assign irq_pin = irq_n_oe ? irq_n_out : 1'b1;
endmodule

// File: verification/alarm_match_interrupt_tb_top.sv
`timescale 1ns/100ps
module alarm_match_interrupt_tb_top;
   // one alarm case: alarm bytes, target select, time, expected flag
   typedef struct packed {
      logic [7:0] amin;
      logic [7:0] ahour;
      logic [7:0] awd;
      logic tsel;
      logic [31:0] tim;
      logic exp;
   } row_t;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, load_val = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, other_req = 1'b0, load = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq_n_out, irq_n_oe, irq, irq_pin;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd_val;
   logic [7:0] cmin, chour, cwd, cdate;
   int error_cnt = 0;
   int samples_checked = 0;
   row_t rows [8];
   // free-running system clock
   always #2.5 sys_clk = ~sys_clk;
   alarm_match_interrupt u_dut (
      .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cur_minute(cmin),
      .cur_hour(chour), .cur_weekday(cwd), .cur_date(cdate),
      .other_irq_req(other_req), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .irq(irq));
   time_counter_model u_time (
      .sys_clk(sys_clk), .rst(rst), .load(load), .load_val(load_val),
      .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .cur_minute(cmin),
      .cur_hour(chour), .cur_weekday(cwd), .cur_date(cdate), .irq_pin(irq_pin));
   // compare one value, count it, report a difference
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // compare one bit, count it, report a difference
   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // axi write of one register; handshakes judged on the settled half cycle
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic a_hs, w_hs, b_hs;
      @(posedge sys_clk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int t = 0; t < 40; t++) begin
         @(negedge sys_clk);
         a_hs = awvalid & awready;
         w_hs = wvalid & wready;
         b_hs = bvalid & bready;
         resp = bresp;
         @(posedge sys_clk);
         if (a_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
         if (b_hs) begin
            bready <= 1'b0;
            return;
         end
      end
      error_cnt++;
   endtask
   // axi read of one register into rd_val and resp
   task automatic rd(input logic [5:0] idx);
      logic a_hs, r_hs;
      @(posedge sys_clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int t = 0; t < 40; t++) begin
         @(negedge sys_clk);
         a_hs = arvalid & arready;
         r_hs = rvalid & rready;
         rd_val = rdata;
         resp = rresp;
         @(posedge sys_clk);
         if (a_hs) arvalid <= 1'b0;
         if (r_hs) begin
            rready <= 1'b0;
            return;
         end
      end
      error_cnt++;
   endtask
   // load a new time into the counter model and let it settle
   task automatic set_time(input logic [31:0] v);
      @(posedge sys_clk);
      load <= 1'b1;
      load_val <= v;
      @(posedge sys_clk);
      load <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask
   // step into the time v from a neighbouring minute, flag cleared between
   task automatic event_at(input logic [31:0] v);
      set_time(v ^ 32'h01000000);
      wr(rtc_alarm_pkg::IDX_EVENT_FLAGS, 8'h00);
      set_time(v);
   endtask
   // print the counts and the verdict, then stop
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      test_done();
   end
   initial begin
      rows = '{'{8'h30, 8'h07, 8'h3e, 1'b0, 32'h30070400, 1'b1},
               '{8'h30, 8'h07, 8'h3e, 1'b0, 32'h30070100, 1'b0},
               '{8'h30, 8'h07, 8'h15, 1'b1, 32'h30070115, 1'b1},
               '{8'h30, 8'h07, 8'h15, 1'b1, 32'h30070414, 1'b0},
               '{8'h59, 8'h23, 8'h80, 1'b0, 32'h59230000, 1'b1},
               '{8'h59, 8'h23, 8'h80, 1'b0, 32'h58230000, 1'b0},
               '{8'h80, 8'h80, 8'h80, 1'b0, 32'h12050209, 1'b1},
               '{8'h30, 8'h80, 8'h15, 1'b1, 32'h30227f15, 1'b1}};
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      // table of match cases, interrupt enable left at zero
      foreach (rows[i]) begin
         wr(rtc_alarm_pkg::IDX_ALARM_MM, rows[i].amin);
         wr(rtc_alarm_pkg::IDX_ALARM_HOUR, rows[i].ahour);
         wr(rtc_alarm_pkg::IDX_ALARM_WD, rows[i].awd);
         wr(rtc_alarm_pkg::IDX_FUNC_SEL, {1'b0, rows[i].tsel, 6'h00});
         event_at(rows[i].tim);
         rd(rtc_alarm_pkg::IDX_EVENT_FLAGS);
         chk_bit(rd_val[3], rows[i].exp);
         chk_bit(irq_pin, 1'b1);
         $display("row %0d done", i);
      end
      // enabled alarm holds the pin until flag or enable drops
      wr(rtc_alarm_pkg::IDX_ALARM_MM, 8'h10);
      wr(rtc_alarm_pkg::IDX_ALARM_HOUR, 8'h80);
      wr(rtc_alarm_pkg::IDX_ALARM_WD, 8'h80);
      wr(rtc_alarm_pkg::IDX_EVENT_FLAGS, 8'h00);
      wr(rtc_alarm_pkg::IDX_INT_CTRL, 8'h08);
      event_at(32'h10000000);
      repeat (50) @(posedge sys_clk);
      @(negedge sys_clk);
      chk_bit(irq_pin, 1'b0);
      wr(rtc_alarm_pkg::IDX_EVENT_FLAGS, 8'hff);
      rd(rtc_alarm_pkg::IDX_EVENT_FLAGS);
      chk(rd_val, 32'h00000008);
      wr(rtc_alarm_pkg::IDX_INT_CTRL, 8'h00);
      @(negedge sys_clk);
      chk_bit(irq_pin, 1'b1);
      wr(rtc_alarm_pkg::IDX_INT_CTRL, 8'h08);
      @(negedge sys_clk);
      chk_bit(irq_pin, 1'b0);
      wr(rtc_alarm_pkg::IDX_EVENT_FLAGS, 8'h00);
      @(negedge sys_clk);
      chk_bit(irq_pin, 1'b1);
      rd(rtc_alarm_pkg::IDX_EVENT_FLAGS);
      chk_bit(rd_val[3], 1'b0);
      $display("pin release done");
      // another source pulls the shared pin with the enable off
      wr(rtc_alarm_pkg::IDX_INT_CTRL, 8'h00);
      other_req <= 1'b1;
      @(negedge sys_clk);
      chk_bit(irq_pin, 1'b0);
      @(posedge sys_clk);
      other_req <= 1'b0;
      // rewriting an alarm equal to the present time gives no event
      wr(rtc_alarm_pkg::IDX_ALARM_MM, 8'h20);
      wr(rtc_alarm_pkg::IDX_ALARM_MM, 8'h10);
      rd(rtc_alarm_pkg::IDX_EVENT_FLAGS);
      chk_bit(rd_val[3], 1'b0);
      // halted clock produces no event
      wr(rtc_alarm_pkg::IDX_INT_CTRL, 8'h02);
      event_at(32'h10000000);
      rd(rtc_alarm_pkg::IDX_EVENT_FLAGS);
      chk_bit(rd_val[3], 1'b0);
      $display("shared, present time, halt done");
      // status, mask and the level interrupt
      wr(rtc_alarm_pkg::IDX_INT_CTRL, 8'h00);
      wr(rtc_alarm_pkg::IDX_IRQ_STATUS, 8'h01);
      event_at(32'h10000000);
      rd(rtc_alarm_pkg::IDX_IRQ_STATUS);
      chk(rd_val, 32'h00000001);
      chk_bit(irq, 1'b0);
      wr(rtc_alarm_pkg::IDX_IRQ_MASK, 8'h01);
      @(negedge sys_clk);
      chk_bit(irq, 1'b1);
      wr(rtc_alarm_pkg::IDX_IRQ_STATUS, 8'h01);
      @(negedge sys_clk);
      chk_bit(irq, 1'b0);
      // clock mirror and an unmapped index
      rd(rtc_alarm_pkg::IDX_CLOCK_MM);
      chk(rd_val, 32'h00000010);
      wr(6'h20, 8'h55);
      chk({30'h0, resp}, {30'h0, rtc_alarm_pkg::RESP_SLVERR});
      rd(6'h20);
      chk({30'h0, resp}, {30'h0, rtc_alarm_pkg::RESP_SLVERR});
      chk(rd_val, 32'h0);
      // alarm register used as plain storage, enable kept at zero
      wr(rtc_alarm_pkg::IDX_ALARM_WD, 8'h5a);
      rd(rtc_alarm_pkg::IDX_ALARM_WD);
      chk(rd_val, 32'h0000005a);
      chk_bit(irq_pin, 1'b1);
      $display("irq and map done");
      // reset in mid-run with the flag set clears the registers
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      rd(rtc_alarm_pkg::IDX_EVENT_FLAGS);
      chk(rd_val, 32'h0);
      rd(rtc_alarm_pkg::IDX_ALARM_WD);
      chk(rd_val, 32'h0);
      rd(rtc_alarm_pkg::IDX_IRQ_MASK);
      chk(rd_val, 32'h0);
      $display("reset done");
      test_done();
   end
endmodule
